/* uhfp_pkg.sv */
// Purpose: constants for the host frame and root port control block
// Assumes: AHB-Lite register access, 32-bit words
// Notes:   offsets are byte addresses
package uhfp_pkg;
  localparam logic [11:0] OFS_HOST_CFG      = 12'h400;
  localparam logic [11:0] OFS_FRAME_INTVL   = 12'h404;
  localparam logic [11:0] OFS_FRAME_CNT     = 12'h408;
  localparam logic [11:0] OFS_PER_TX_SPACE  = 12'h410;
  localparam logic [11:0] OFS_CH_IRQ_PEND   = 12'h414;
  localparam logic [11:0] OFS_CH_IRQ_EN     = 12'h418;
  localparam logic [11:0] OFS_PORT_CTRL     = 12'h440;
  localparam logic [15:0] FRAME_INTVL_RST   = 16'hea60;
  localparam logic [15:0] FRAME_NUM_RST     = 16'h3fff;
  localparam logic [15:0] FRAME_NUM_MAX     = 16'h3fff;
  localparam logic [1:0]  CLK_SEL_60        = 2'h0;
  localparam logic [1:0]  CLK_SEL_48        = 2'h1;
  localparam logic [1:0]  CLK_SEL_6         = 2'h2;
  localparam logic [1:0]  SPD_HIGH          = 2'h0;
  localparam logic [1:0]  SPD_FULL          = 2'h1;
  localparam logic [1:0]  SPD_LOW           = 2'h2;
  localparam logic [2:0]  LS_DIV_LAST       = 3'h7;
  localparam logic [3:0]  TEST_MAX          = 4'h5;
  // derived frame intervals: 125 us or 1 ms times phy clock
  localparam int          HS_FRAME_SCALE    = 125;
  localparam int          FSLS_FRAME_SCALE  = 1000;
  localparam logic [15:0] INTVL_HS_60       = 16'(60 * HS_FRAME_SCALE);
  localparam logic [15:0] INTVL_FS_60       = 16'(60 * FSLS_FRAME_SCALE);
  localparam logic [15:0] INTVL_FS_48       = 16'(48 * FSLS_FRAME_SCALE);
  localparam logic [15:0] INTVL_LS_6        = 16'(6 * FSLS_FRAME_SCALE);
  // bit positions
  localparam int          B_FSLS_ONLY       = 2;
  localparam int          B_RELOAD_OK       = 16;
  localparam int          B_CONN_STS        = 0;
  localparam int          B_CONN_DET        = 1;
  localparam int          B_PORT_EN         = 2;
  localparam int          B_EN_CHG          = 3;
  localparam int          B_OC_ACT          = 4;
  localparam int          B_OC_CHG          = 5;
  localparam int          B_PORT_RST        = 8;
  localparam int          B_PORT_PWR        = 12;
endpackage : uhfp_pkg

/* uhfp_host_port.sv */
// Purpose: host frame timing, periodic status, channel irq and root port
// Assumes: clk is the phy clock domain, AHB-Lite single word transfers
// Notes:   zero-wait slave, always OKAY
`timescale 1ns/1ps
module uhfp_host_port
  import uhfp_pkg::*;
#(
  parameter int CH_N = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         dev_connected,
  input  wire logic [1:0]   dev_max_speed,
  input  wire logic         overcurrent,
  input  wire logic [1:0]   line_state,
  input  wire logic [CH_N-1:0] channel_irq_in,
  input  wire logic [7:0]   periodic_queue_head,
  input  wire logic [4:0]   periodic_queue_free,
  input  wire logic [15:0]  periodic_fifo_free,
  output logic              sof_pulse,
  output logic              ls_clk_tick,
  output logic              port_reset_drive,
  output logic              port_power_on,
  output logic [3:0]        port_test_mode,
  output logic [1:0]        attached_speed_out,
  output logic              core_channel_irq,
  output logic              core_port_irq
);
  import uhfp_pkg::*;

  typedef struct packed {
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic        fs_ls_only_select;
    logic [1:0]  phy_clock_select;
    logic        interval_reload_allow;
    logic [15:0] frame_interval;
    logic        interval_set;
    logic [15:0] frame_time_left;
    logic [15:0] frame_count;
    logic [CH_N-1:0] channel_irq_mask_bits;
    logic [CH_N-1:0] ch_pend;
    logic        conn_sts;
    logic        connect_detected;
    logic        port_enabled;
    logic        en_chg;
    logic        oc_act;
    logic        oc_chg;
    logic        port_reset_ctl;
    logic        port_power_ctl;
    logic [3:0]  port_test_select;
    logic [1:0]  attached_speed;
    logic [2:0]  ls_div;
    logic        sof;
    logic        ls_tick;
    logic        ch_irq;
    logic        port_irq;
  } uhfp_state_t;

  uhfp_state_t s_r;
  uhfp_state_t s_nxt;

  // frame length when software has not programmed one
  function automatic logic [15:0] default_interval(input logic [1:0] sel,
                                                   input logic [1:0] spd);
    logic [15:0] v;
    v = INTVL_FS_60;
    if (spd == SPD_HIGH) begin
      v = INTVL_HS_60;
    end else if (sel == CLK_SEL_48) begin
      v = INTVL_FS_48;
    end else if (sel == CLK_SEL_6 && spd == SPD_LOW) begin
      v = INTVL_LS_6;
    end
    return v;
  endfunction : default_interval

  function automatic logic [31:0] read_mux(input uhfp_state_t st,
                                           input logic [11:0] a,
                                           input logic [7:0] qh,
                                           input logic [4:0] qf,
                                           input logic [15:0] ff);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      OFS_HOST_CFG: begin
        d[B_FSLS_ONLY] = st.fs_ls_only_select;
        d[1:0] = st.phy_clock_select;
      end
      OFS_FRAME_INTVL: begin
        d[B_RELOAD_OK] = st.interval_reload_allow;
        d[15:0] = st.frame_interval;
      end
      OFS_FRAME_CNT: d = {st.frame_time_left, st.frame_count};
      OFS_PER_TX_SPACE: d = {qh, 3'h0, qf, ff};
      OFS_CH_IRQ_PEND: d[CH_N-1:0] = st.ch_pend;
      OFS_CH_IRQ_EN: d[CH_N-1:0] = st.channel_irq_mask_bits;
      OFS_PORT_CTRL: begin
        d[18:17] = st.attached_speed;
        d[16:13] = st.port_test_select;
        d[B_PORT_PWR] = st.port_power_ctl;
        d[11:10] = line_state;
        d[B_PORT_RST] = st.port_reset_ctl;
        d[B_OC_CHG] = st.oc_chg;
        d[B_OC_ACT] = st.oc_act;
        d[B_EN_CHG] = st.en_chg;
        d[B_PORT_EN] = st.port_enabled;
        d[B_CONN_DET] = st.connect_detected;
        d[B_CONN_STS] = st.conn_sts;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  logic        acc;
  logic [31:0] w;
  logic        port_en_nxt;
  logic        ld_intvl;

  always_comb begin
    s_nxt = s_r;
    acc = hsel && hready && htrans[1];
    w = hwdata;
    ld_intvl = 1'b0;
    port_en_nxt = s_r.port_enabled;
    s_nxt.wr_pend = acc && hwrite;
    s_nxt.wr_addr = haddr[11:0];
    if (acc && !hwrite) begin
      s_nxt.rdata = read_mux(s_r, haddr[11:0], periodic_queue_head,
                             periodic_queue_free, periodic_fifo_free);
    end

    // ls tick is every eighth clock, only with CLK_SEL_6 selected
    s_nxt.ls_div = s_r.ls_div + 3'h1;
    s_nxt.ls_tick = (s_r.phy_clock_select == CLK_SEL_6) && (s_r.ls_div == LS_DIV_LAST);

    s_nxt.sof = 1'b0;
    if (s_r.port_enabled) begin
      if (s_r.frame_time_left == 16'h0000) begin
        s_nxt.frame_time_left = s_r.frame_interval;
        s_nxt.sof = 1'b1;
        s_nxt.frame_count = (s_r.frame_count >= FRAME_NUM_MAX) ? 16'h0000
                            : s_r.frame_count + 16'h0001;
      end else begin
        s_nxt.frame_time_left = s_r.frame_time_left - 16'h0001;
      end
    end

    s_nxt.conn_sts = dev_connected;
    s_nxt.attached_speed = (s_r.fs_ls_only_select && dev_max_speed == SPD_HIGH)
                           ? SPD_FULL : dev_max_speed;

    s_nxt.ch_pend = channel_irq_in;
    s_nxt.ch_irq = |(s_r.ch_pend & s_r.channel_irq_mask_bits);

    if (!s_r.interval_set) begin
      s_nxt.frame_interval = default_interval(s_r.phy_clock_select, s_r.attached_speed);
    end

    if (s_r.wr_pend) begin
      case (s_r.wr_addr)
        OFS_HOST_CFG: begin
          s_nxt.fs_ls_only_select = w[B_FSLS_ONLY];
          if (w[1:0] != 2'h3) begin
            s_nxt.phy_clock_select = w[1:0];
          end
        end
        OFS_FRAME_INTVL: begin
          s_nxt.interval_reload_allow = w[B_RELOAD_OK];
          if (s_r.port_enabled) begin
            ld_intvl = 1'b1;
          end
        end
        OFS_CH_IRQ_EN: s_nxt.channel_irq_mask_bits = w[CH_N-1:0];
        OFS_PORT_CTRL: begin
          if (w[16:13] <= TEST_MAX) begin
            s_nxt.port_test_select = w[16:13];
          end
          s_nxt.port_power_ctl = w[B_PORT_PWR];
          s_nxt.port_reset_ctl = w[B_PORT_RST];
          if (w[B_PORT_EN]) begin
            port_en_nxt = 1'b0;
          end
          if (w[B_CONN_DET]) begin
            s_nxt.connect_detected = 1'b0;
          end
          if (w[B_EN_CHG]) begin
            s_nxt.en_chg = 1'b0;
          end
          if (w[B_OC_CHG]) begin
            s_nxt.oc_chg = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (ld_intvl) begin
      s_nxt.frame_interval = w[15:0];
      s_nxt.interval_set = 1'b1;
    end

    // enabled at end of reset, lost on fault
    if (s_r.port_reset_ctl && !s_nxt.port_reset_ctl && s_r.conn_sts) begin
      port_en_nxt = 1'b1;
    end
    if (overcurrent || !dev_connected) begin
      port_en_nxt = 1'b0;
    end
    s_nxt.port_enabled = port_en_nxt;
    s_nxt.oc_act = overcurrent;
    if (overcurrent) begin
      s_nxt.port_power_ctl = 1'b0;
    end
    // sets placed last so they win over clears
    if (dev_connected && !s_r.conn_sts) begin
      s_nxt.connect_detected = 1'b1;
    end
    if (port_en_nxt != s_r.port_enabled) begin
      s_nxt.en_chg = 1'b1;
    end
    if (overcurrent != s_r.oc_act) begin
      s_nxt.oc_chg = 1'b1;
    end
    s_nxt.port_irq = s_r.connect_detected | s_r.en_chg | s_r.oc_chg;

    if (sys_rst) begin
      s_nxt = '0;
      s_nxt.frame_interval = FRAME_INTVL_RST;
      s_nxt.frame_count = FRAME_NUM_RST;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sof_pulse = s_r.sof;
  assign ls_clk_tick = s_r.ls_tick;
  assign port_reset_drive = s_r.port_reset_ctl;
  assign port_power_on = s_r.port_power_ctl;
  assign port_test_mode = s_r.port_test_select;
  assign attached_speed_out = s_r.attached_speed;
  assign core_channel_irq = s_r.ch_irq;
  assign core_port_irq = s_r.port_irq;
endmodule : uhfp_host_port

/* uhfp_properties.sv */
// Purpose: port checks for uhfp_host_port
// Assumes: hready is tied to hreadyout
// Notes:   port writes land one edge after the data phase
`timescale 1ns/1ps
module uhfp_properties #(
  parameter int CH_N = 16
) (
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [31:0]     hwdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic            dev_connected,
  input wire logic            overcurrent,
  input wire logic [CH_N-1:0] channel_irq_in,
  input wire logic            sof_pulse,
  input wire logic            ls_clk_tick,
  input wire logic            port_reset_drive,
  input wire logic            port_power_on,
  input wire logic [3:0]      port_test_mode,
  input wire logic            core_channel_irq,
  input wire logic            core_port_irq
);
  import uhfp_pkg::*;
  logic wr_port_r;
  // data phase of a port write
  always_ff @(posedge clk) begin
    wr_port_r <= !sys_rst && hsel && htrans[1] && hwrite && haddr[11:0] == OFS_PORT_CTRL;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence port_wr;
    wr_port_r;
  endsequence
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_reset_start:
    assert property (port_wr ##0 hwdata[8] |-> ##[1:2] port_reset_drive)
    else $error("port reset not driven");
  a_test_follow:
    assert property (port_wr ##0 hwdata[16:13] <= TEST_MAX
      |=> port_test_mode == $past(hwdata[16:13])) else $error("test mode wrong");
  a_power_on:
    assert property (port_wr ##0 (hwdata[12] && !overcurrent) |-> ##[1:2] port_power_on)
    else $error("power not on");
  a_oc_power:
    assert property ($rose(overcurrent) |-> ##[1:3] !port_power_on)
    else $error("power kept on overcurrent");
  a_tick_gap:
    assert property (ls_clk_tick |=> !ls_clk_tick [*7]) else $error("tick too soon");
  a_sof_gap:
    assert property (sof_pulse |=> !sof_pulse [*8]) else $error("sof too soon");
  a_chan_quiet:
    assert property ((channel_irq_in == '0) [*3] |-> !core_channel_irq)
    else $error("channel irq without cause");
  a_conn_irq:
    assert property ($rose(dev_connected) |-> ##[1:4] core_port_irq)
    else $error("no port irq on connect");
endmodule : uhfp_properties
bind uhfp_host_port uhfp_properties #(.CH_N(CH_N)) uhfp_properties_i (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .dev_connected(dev_connected), .overcurrent(overcurrent),
  .channel_irq_in(channel_irq_in), .sof_pulse(sof_pulse), .ls_clk_tick(ls_clk_tick),
  .port_reset_drive(port_reset_drive), .port_power_on(port_power_on),
  .port_test_mode(port_test_mode), .core_channel_irq(core_channel_irq),
  .core_port_irq(core_port_irq));

/* uhfp_usb_dev_model.sv */
// Purpose: attached usb device on the root port
// Assumes: host pull-downs on both data lines
// Notes:   idle lines only, no packets
`timescale 1ns/1ps
module uhfp_usb_dev_model (
  input  wire logic       clk,
  input  wire logic       plug,
  input  wire logic [1:0] speed,
  input  wire logic       fault,
  output logic            dev_connected,
  output logic [1:0]      dev_max_speed,
  output logic            overcurrent,
  output logic [1:0]      line_state
);
  always_ff @(posedge clk) begin
    dev_connected <= plug;
    dev_max_speed <= speed;
    overcurrent   <= fault;
    // detached lines fall to se0; low speed idles on d-
    line_state    <= !plug ? 2'b00 : (speed == 2'b10) ? 2'b10 : 2'b01;
  end
endmodule : uhfp_usb_dev_model

/* uhfp_host_port_test.sv */
// Purpose: register level test of uhfp_host_port
// Assumes: zero-wait slave, 40 MHz clock
// Notes:   port reset hold is shortened to keep the run short
`timescale 1ns/1ps
module uhfp_host_port_test;
  import uhfp_pkg::*;
  logic        clk, sys_rst, hsel, hwrite, plug, fault, hreadyout, hresp, sof_pulse;
  logic        ls_clk_tick, port_reset_drive, port_power_on, core_channel_irq;
  logic        core_port_irq, dev_connected, overcurrent;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, speed, dev_max_speed, line_state;
  logic [15:0] chan_in, f_free;
  logic [7:0]  q_head;
  logic [4:0]  q_free;
  logic [3:0]  port_test_mode;
  int          n_errors = 0, comparisons = 0, nsof = 0;
  uhfp_host_port #(.CH_N(16)) uhfp_host_port_i (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dev_connected(dev_connected), .dev_max_speed(dev_max_speed),
    .overcurrent(overcurrent), .line_state(line_state), .channel_irq_in(chan_in),
    .periodic_queue_head(q_head), .periodic_queue_free(q_free),
    .periodic_fifo_free(f_free), .sof_pulse(sof_pulse), .ls_clk_tick(ls_clk_tick),
    .port_reset_drive(port_reset_drive), .port_power_on(port_power_on),
    .port_test_mode(port_test_mode), .attached_speed_out(),
    .core_channel_irq(core_channel_irq), .core_port_irq(core_port_irq));
  uhfp_usb_dev_model uhfp_usb_dev_model_i (.clk(clk), .plug(plug), .speed(speed),
    .fault(fault), .dev_connected(dev_connected), .dev_max_speed(dev_max_speed),
    .overcurrent(overcurrent), .line_state(line_state));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sof_pulse === 1'b1) nsof <= nsof + 1;
  end
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask : wait_rdy
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(what, q & m, e);
  endtask : rd
  // first pulse syncs, second gives the distance in clocks
  task automatic gap(input string what, input bit tick, input int exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
        if (n > 9000) begin
          n_errors++;
          conclude();
        end
      end while ((tick ? ls_clk_tick : sof_pulse) !== 1'b1);
    end
    chk(what, n, exp);
  endtask : gap
  task automatic port_rst(input logic [31:0] spd);
    wr(OFS_PORT_CTRL, 32'h0000_1100);
    repeat (40) @(posedge clk);
    chk("rst drive", 32'(port_reset_drive), 32'h1);
    wr(OFS_PORT_CTRL, 32'h0000_1000);
    rd("enable", OFS_PORT_CTRL, spd | 32'h4, 32'h0006_0104);
  endtask : port_rst
  initial begin
    {sys_rst, plug, fault, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {chan_in, f_free, q_head, q_free} = '0;
    sys_rst = 1'b1;
    speed = 2'b10;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd("ivl", OFS_FRAME_INTVL, 32'h0000_ea60);
    rd("frame", OFS_FRAME_CNT, 32'h0000_3fff);
    rd("mask", OFS_CH_IRQ_EN, 32'h0);
    rd("unmapped", 12'h480, 32'h0);
    wr(OFS_FRAME_INTVL, 32'h0000_0100);
    rd("ivl", OFS_FRAME_INTVL, 32'h0000_ea60);
    wr(OFS_CH_IRQ_EN, 32'h0000_0005);
    chan_in <= 16'h0002;
    repeat (4) @(posedge clk);
    chk("ch irq", 32'(core_channel_irq), 32'h0);
    wr(OFS_CH_IRQ_PEND, 32'h0);
    rd("pend", OFS_CH_IRQ_PEND, 32'h0000_0002);
    chan_in <= 16'h0006;
    repeat (4) @(posedge clk);
    chk("ch irq", 32'(core_channel_irq), 32'h1);
    {q_head, q_free, f_free, chan_in} <= {8'ha5, 5'h10, 16'h8000, 16'h0};
    rd("ptx", OFS_PER_TX_SPACE, 32'ha510_8000);
    wr(OFS_PER_TX_SPACE, 32'h0);
    {q_free, f_free} <= '0;
    rd("ptx", OFS_PER_TX_SPACE, 32'ha500_0000);
    $display("end of status test");
    wr(OFS_HOST_CFG, 32'h0000_0002);
    plug <= 1'b1;
    repeat (4) @(posedge clk);
    chk("port irq", 32'(core_port_irq), 32'h1);
    rd("port", OFS_PORT_CTRL, 32'h0000_0803, 32'h0000_0c03);
    wr(OFS_PORT_CTRL, 32'h0000_1006);
    rd("port", OFS_PORT_CTRL, 32'h0000_1000, 32'h0000_1006);
    repeat (2) @(posedge clk);
    chk("port irq", 32'(core_port_irq), 32'h0);
    port_rst(32'h0004_0000);
    gap("tick gap", 1, 8);
    gap("sof gap", 0, 6001);
    @(posedge clk);
    rd("frame", OFS_FRAME_CNT, 32'((nsof - 1) % 16384), 32'h0000_ffff);
    wr(OFS_FRAME_INTVL, 32'h0001_0014);
    rd("ivl", OFS_FRAME_INTVL, 32'h0001_0014);
    gap("sof gap", 0, 21);
    @(posedge clk);
    rd("frame", OFS_FRAME_CNT, 32'((nsof - 1) % 16384), 32'h0000_ffff);
    $display("end of frame test");
    for (int c = 1; c < 7; c++) begin
      wr(OFS_PORT_CTRL, 32'h0000_1000 | (c << 13));
      @(posedge clk);
      chk("test mode", 32'(port_test_mode), (c > 5) ? 32'h5 : 32'(c));
    end
    wr(OFS_PORT_CTRL, 32'h0000_1000);
    plug <= 1'b0;
    repeat (4) @(posedge clk);
    rd("enable", OFS_PORT_CTRL, 32'h0, 32'h0000_0005);
    wr(OFS_HOST_CFG, 32'h0000_0004);
    {speed, plug} <= 3'b001;
    repeat (4) @(posedge clk);
    port_rst(32'h0002_0000);
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    chk("power", 32'(port_power_on), 32'h0);
    rd("port", OFS_PORT_CTRL, 32'h0000_0030, 32'h0000_1034);
    chk("port irq", 32'(core_port_irq), 32'h1);
    $display("end of port test");
    conclude();
  end
endmodule : uhfp_host_port_test
